// [aem_pkg.sv]
// Shared constants and types of the absolute encoder four-slave map
`default_nettype none

package aem_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int POS_W  = 13;          // Single-turn position width
	localparam int NIB_W  = 4;           // One slave data nibble
	localparam int ADDR_W = 3;           // Register port address width
	localparam int FIFO_DEPTH = 32;      // Sample buffer depth

	////////////////////////////////////////////////////////////////////////////
	// Register port map: data nibble of each slave, then parameter nibble
	localparam logic [ADDR_W-1:0] ADDR_DATA_A  = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_DATA_B  = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_DATA_C  = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_DATA_D  = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_PARAM_A = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_PARAM_B = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_PARAM_C = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_PARAM_D = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Field positions inside a slave nibble
	localparam int NIB_BIT_ZERO  = 0;
	localparam int NIB_BIT_ONE   = 1;
	localparam int NIB_BIT_TWO   = 2;
	localparam int NIB_BIT_THREE = 3;
	localparam int FLAG_POS_BITS = 3;    // Position bits per slave in flag mode

	// Two-bit command codes, first named bit on the left
	localparam logic [1:0] CMD_01 = 2'h1;
	localparam logic [1:0] CMD_10 = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Preset targets and reset values
	localparam logic [POS_W-1:0] POS_QUARTER = 13'h0800;
	localparam logic [POS_W-1:0] POS_ZERO    = 13'h0000;
	localparam logic [POS_W-1:0] POS_RST     = 13'h0000;
	localparam logic [NIB_W-1:0] NIB_RST     = 4'h0;
	localparam logic [1:0]       CMD_RST     = 2'h0;

	// Slave A parameter nibble
	typedef struct packed {
		logic spare_parameter;
		logic count_direction_select;
		logic flag_mode_select;
		logic code_type_select;
	} aem_param_t;

	localparam aem_param_t PARAM_RST = 4'h0;

endpackage

`default_nettype wire

// [aem_fifo.sv]
// Sample FIFO with valid and ready on both sides
`default_nettype none

module aem_fifo #(
	parameter int W     = 13,
	parameter int DEPTH = 32
) (
	input  wire logic         mclk,      // System clock
	input  wire logic         nrst,      // Async reset, active low
	input  wire logic         ce,        // Clock enable, freezes state
	input  wire logic [W-1:0] in_data,   // Sample in
	input  wire logic         in_valid,  // Sample in present
	output var  logic         in_ready,  // Room for a sample
	output logic      [W-1:0] out_data,  // Oldest sample
	output var  logic         out_valid, // Oldest sample present
	input  wire logic         out_ready  // Drain takes sample
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	wire           push;
	wire           pop;

	// Handshakes and occupancy
	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rp_r];

	// Pointers wrap naturally, so depth must be a power of two
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else if (ce) begin
			wp_r      <= push ? wp_r + 1'b1 : wp_r;
			rp_r      <= pop ? rp_r + 1'b1 : rp_r;
			cnt_r     <= cnt_nxt;
			in_ready  <= cnt_nxt != (AW+1)'(DEPTH);
			out_valid <= cnt_nxt != '0;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge mclk) begin
		if (ce && push) begin
			mem[wp_r] <= in_data;
		end
	end

endmodule // aem_fifo

`default_nettype wire

// [aem_map.sv]
// Absolute encoder position mapped onto four bus slave nibbles
//
// The address map and the strobed register port were decided locally.
`default_nettype none

module aem_map #(
	parameter int POS_W      = aem_pkg::POS_W,
	parameter int FIFO_DEPTH = aem_pkg::FIFO_DEPTH
) (
	input  wire logic               mclk,                   // System clock, 25 MHz
	input  wire logic               nrst,                   // Async reset, active low
	input  wire logic               ce,                     // Clock enable
	input  wire logic [2:0]         addr,                   // Register address
	input  wire logic [3:0]         wdata,                  // Write nibble
	input  wire logic               wr,                     // Write strobe
	input  wire logic               rd,                     // Read strobe
	output var  logic [3:0]         rdata,                  // Read nibble, one cycle later
	input  wire logic [POS_W-1:0]   sens_data,              // Raw angle, rises clockwise
	input  wire logic               sens_valid,             // Raw angle present
	output var  logic               sens_ready,             // Buffer accepts angle
	output var  logic               latch_pulse,            // Position stored this cycle
	output var  logic               code_type_select,       // 1 binary, 0 Gray
	output var  logic               flag_mode_select,       // 1 without flags
	output var  logic               count_direction_select  // 1 up clockwise
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	aem_pkg::aem_param_t param_r;
	logic [3:0]       prev_out_r;
	logic [POS_W-1:0] cur_raw_r;
	logic [POS_W-1:0] offset_r;
	logic [POS_W-1:0] stored_r;
	logic             flag_r;
	logic [POS_W-1:0] fifo_data;
	logic             fifo_valid;
	logic [3:0]       nib [4];
	logic [3:0]       rdata_nxt;

	wire              wr_data_a;
	wire              wr_param_a;
	wire              drain_rdy;
	wire              pop;
	wire [1:0]        latch_new;
	wire [1:0]        latch_old;
	wire [1:0]        preset_cmd;
	wire              latch_hit;
	wire [POS_W-1:0]  dir_pos;
	wire [POS_W-1:0]  live_pos;
	wire [POS_W-1:0]  code_word;
	wire [POS_W-1:0]  preset_target;
	wire              preset_hit;
	wire              rd_nib;

	////////////////////////////////////////////////////////////////////////////
	// Sample buffer between sensor and position logic
	aem_fifo #(
		.W     (POS_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.ce        (ce),
		.in_data   (sens_data),
		.in_valid  (sens_valid),
		.in_ready  (sens_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (drain_rdy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write decode
	// slave A parameters only
	assign wr_param_a = wr && (addr == aem_pkg::ADDR_PARAM_A);
	assign wr_data_a  = wr && (addr == aem_pkg::ADDR_DATA_A);
	// Stall the drain during a slave A write so a preset sees a steady angle
	assign drain_rdy  = !wr_data_a;
	assign pop        = fifo_valid & drain_rdy;

	// Command pairs, first named bit on the left
	assign latch_new  = {wdata[aem_pkg::NIB_BIT_TWO], wdata[aem_pkg::NIB_BIT_THREE]};
	assign latch_old  = {prev_out_r[aem_pkg::NIB_BIT_TWO], prev_out_r[aem_pkg::NIB_BIT_THREE]};
	assign preset_cmd = {wdata[aem_pkg::NIB_BIT_ZERO], wdata[aem_pkg::NIB_BIT_ONE]};

	// store only on 01 to 10 or 10 to 01
	// compared against the previous slave A output
	assign latch_hit  = wr_data_a &&
		(((latch_old == aem_pkg::CMD_01) && (latch_new == aem_pkg::CMD_10)) ||
		 ((latch_old == aem_pkg::CMD_10) && (latch_new == aem_pkg::CMD_01)));

	// preset codes, 00 and 11 leave the position alone
	assign preset_hit    = wr_data_a && ((preset_cmd == aem_pkg::CMD_01) || (preset_cmd == aem_pkg::CMD_10));
	assign preset_target = (preset_cmd == aem_pkg::CMD_01) ? aem_pkg::POS_QUARTER : aem_pkg::POS_ZERO;

	////////////////////////////////////////////////////////////////////////////
	// Position path
	// counting down negates the clockwise angle modulo one turn
	assign dir_pos   = param_r.count_direction_select ? cur_raw_r : POS_W'(-cur_raw_r);
	assign live_pos  = POS_W'(dir_pos + offset_r);
	assign code_word = param_r.code_type_select ? live_pos : (live_pos ^ (live_pos >> 1));

	// Parameter bits and last slave A output
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			param_r    <= aem_pkg::PARAM_RST;
			prev_out_r <= aem_pkg::NIB_RST;
		end else if (ce) begin
			// only slave A parameter writes land
			if (wr_param_a) begin
				param_r <= wdata;
			end
			if (wr_data_a) begin
				prev_out_r <= wdata;
			end
		end
	end

	// Angle tracking and preset offset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cur_raw_r <= aem_pkg::POS_RST;
			offset_r  <= aem_pkg::POS_RST;
		end else if (ce) begin
			if (pop) begin
				cur_raw_r <= fifo_data;
			end
			// offset makes the live position hit the target
			if (preset_hit) begin
				offset_r <= POS_W'(preset_target - dir_pos);
			end
		end
	end

	// Stored word and its flag; the latch uses the position before any preset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stored_r    <= aem_pkg::POS_RST;
			flag_r      <= 1'b0;
			latch_pulse <= 1'b0;
		end else if (ce) begin
			latch_pulse <= latch_hit;
			if (latch_hit) begin
				stored_r <= code_word;
				// flag follows output bit two of this command
				flag_r   <= wdata[aem_pkg::NIB_BIT_TWO];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slave input nibbles
	// all four slaves carry the one stored word
	// flag mode leaves three bits per slave, twelve in all
	for (genvar s = 0; s < 4; s++) begin : g_nib
		localparam int LO_NF = s * aem_pkg::NIB_W;
		localparam int LO_F  = s * aem_pkg::FLAG_POS_BITS;
		wire [3:0] nf_nib;
		// four bits per slave, slave D holds bit 12 alone
		if (s < 3) begin : g_full
			assign nf_nib = stored_r[LO_NF +: 4];
		end else begin : g_top
			assign nf_nib = {3'h0, stored_r[LO_NF]};
		end
		// format chosen by slave A parameter bit one
		// three position bits plus flag on bit three
		assign nib[s] = param_r.flag_mode_select ? nf_nib : {flag_r, stored_r[LO_F +: 3]};
	end

	// Read select, unmapped and parameter reads return zero
	assign rd_nib    = rd && !addr[2];
	assign rdata_nxt = rd_nib ? nib[addr[1:0]] : aem_pkg::NIB_RST;

	// reads show the word stored before this cycle's latch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata <= aem_pkg::NIB_RST;
		end else if (ce) begin
			rdata <= rdata_nxt;
		end
	end

	// Configuration levels for the rest of the encoder
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			code_type_select       <= 1'b0;
			flag_mode_select       <= 1'b0;
			count_direction_select <= 1'b0;
		end else if (ce) begin
			code_type_select       <= param_r.code_type_select;
			flag_mode_select       <= param_r.flag_mode_select;
			count_direction_select <= param_r.count_direction_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_param_only_a;
		ce && wr && addr[2] && (addr != aem_pkg::ADDR_PARAM_A) |=> $stable(param_r);
	endproperty
	a_param_only_a: assert property (p_param_only_a) else $error("parameter write to B, C or D took effect");

	property p_gray_latch;
		ce && latch_hit && !param_r.code_type_select |=> stored_r == ($past(live_pos) ^ ($past(live_pos) >> 1));
	endproperty
	a_gray_latch: assert property (p_gray_latch) else $error("Gray stored word wrong");

	property p_noflag_a;
		ce && rd && (addr == aem_pkg::ADDR_DATA_A) && param_r.flag_mode_select |=> rdata == $past(stored_r[3:0]);
	endproperty
	a_noflag_a: assert property (p_noflag_a) else $error("slave A nibble wrong without flags");

	property p_out_only_a;
		ce && wr && (addr == aem_pkg::ADDR_DATA_B) |=> $stable(prev_out_r) && !latch_pulse;
	endproperty
	a_out_only_a: assert property (p_out_only_a) else $error("slave B accepted output data");

	property p_latch;
		ce && wr_data_a && (prev_out_r[3] != prev_out_r[2]) && (wdata[3:2] == ~prev_out_r[3:2])
			|=> latch_pulse && (flag_r == $past(wdata[aem_pkg::NIB_BIT_TWO]));
	endproperty
	a_latch: assert property (p_latch) else $error("latch transition missed");

	property p_no_latch;
		ce && wr_data_a && (wdata[3:2] == prev_out_r[3:2]) |=> !latch_pulse && $stable(stored_r);
	endproperty
	a_no_latch: assert property (p_no_latch) else $error("latch without transition");

	property p_preset_zero;
		ce && wr_data_a && (wdata[1:0] == 2'h1) |=> live_pos == aem_pkg::POS_ZERO;
	endproperty
	a_preset_zero: assert property (p_preset_zero) else $error("zero preset not applied");

	property p_top_slave;
		ce && rd && (addr == aem_pkg::ADDR_DATA_D) && param_r.flag_mode_select |=> rdata[3:1] == 3'h0;
	endproperty
	a_top_slave: assert property (p_top_slave) else $error("slave D unused bits set");

	property p_flag_bit;
		ce && rd && !addr[2] && !param_r.flag_mode_select |=> rdata[3] == $past(flag_r);
	endproperty
	a_flag_bit: assert property (p_flag_bit) else $error("flag bit differs from stored flag");

	property p_stored_hold;
		ce && !latch_hit |=> $stable(stored_r) && $stable(flag_r);
	endproperty
	a_stored_hold: assert property (p_stored_hold) else $error("stored word moved without latch");

	property p_quarter;
		ce && wr_data_a && (wdata[1:0] == 2'h2) |=> live_pos == aem_pkg::POS_QUARTER;
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter preset not applied");

	property p_flag_slice;
		ce && rd && (addr == aem_pkg::ADDR_DATA_A) && !param_r.flag_mode_select
			|=> rdata[2:0] == $past(stored_r[2:0]);
	endproperty
	a_flag_slice: assert property (p_flag_slice) else $error("slave A position bits wrong with flags");

	property p_param_a;
		ce && wr_param_a |=> param_r == aem_pkg::aem_param_t'($past(wdata));
	endproperty
	a_param_a: assert property (p_param_a) else $error("slave A parameter write lost");

	property p_prev_hold;
		ce && !wr_data_a |=> $stable(prev_out_r);
	endproperty
	a_prev_hold: assert property (p_prev_hold) else $error("remembered output moved without write");

	property p_ce_freeze;
		!ce |=> $stable(stored_r) && $stable(flag_r) && $stable(param_r);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

	// Scenarios the bench is meant to reach
	c_latch:       cover property (ce && latch_hit);
	c_flag_latch:  cover property (ce && latch_hit && !param_r.flag_mode_select);
	c_flag_read:   cover property (ce && rd && !addr[2] && !param_r.flag_mode_select);
	c_preset_q:    cover property (ce && wr_data_a && (wdata[1:0] == 2'h2));
	c_fifo_full:   cover property (!sens_ready);

endmodule // aem_map

`default_nettype wire

// [aem_master_model.sv]
// Bus master model that polls the four encoder slaves over the register port
`default_nettype none

module aem_master_model (
	input  wire logic       mclk,  // System clock
	input  wire logic [3:0] rdata, // Read nibble
	output var  logic [2:0] addr,  // Slave address
	output var  logic [3:0] wdata, // Output nibble
	output var  logic       wr,    // Write strobe
	output var  logic       rd     // Read strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		{addr, wdata, wr, rd} = '0;
	end

	// Write of one nibble, repeated n times back to back
	task automatic write(input logic [2:0] a, input logic [3:0] d, input int n = 1);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		repeat (n) @(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read; data is taken in the cycle after the strobe only
	task automatic read(input logic [2:0] a, output logic [3:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// distinct consecutive addresses
	// Polls A to D in order, close together; word is {D,C,B,A}
	task automatic poll(input logic flags, output logic [15:0] w, output logic ok);
		logic [3:0] n;
		for (int s = 0; s < 4; s++) begin
			read(3'(s), n);
			w[4*s +: 4] = n;
		end
		ok = !flags || (w[3] == w[7] && w[7] == w[11] && w[11] == w[15]);
	endtask
endmodule // aem_master_model

`default_nettype wire

// [test_absolute_encoder_four_slave_map.sv]
// Self-checking bench of the encoder four-slave map
`default_nettype none

module test_absolute_encoder_four_slave_map;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        sens_valid = 1'b0;
	logic [12:0] sens_data = 13'h0000;
	logic [2:0]  addr;
	logic [3:0]  wdata;
	logic [3:0]  rdata;
	logic        wr;
	logic        rd;
	logic        sens_ready;
	logic        latch_pulse;
	logic        code_type_select;
	logic        flag_mode_select;
	logic        count_direction_select;
	logic [15:0] w;
	logic        ok;
	logic        rdy;
	logic        full_seen = 1'b0;
	int          fails = 0;
	int          tests_run = 0;
	int          taken = 0;
	int          cycles = 0;

	always #20 mclk = ~mclk;

	aem_map u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sens_data(sens_data), .sens_valid(sens_valid), .sens_ready(sens_ready),
		.latch_pulse(latch_pulse), .code_type_select(code_type_select),
		.flag_mode_select(flag_mode_select), .count_direction_select(count_direction_select));

	aem_master_model u_bm (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	////////////////////////////////////////////////////////////////////////////
	// Checking and closing
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard, well above the couple of hundred cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("ERROR %0t: run did not finish", $time);
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slave data write, then latch pulse looked at in the cycle after
	task automatic wl(input logic [2:0] a, input logic [3:0] d, input logic lp);
		u_bm.write(a, d);
		#1 chk(16'(latch_pulse), 16'(lp), "latch pulse");
	endtask

	// Full poll of the four slaves against an expected word
	task automatic pw(input logic flags, input logic [15:0] exp);
		u_bm.poll(flags, w, ok);
		chk(w, exp, "polled word");
		chk(16'(ok), 16'h1, "flag agreement");
	endtask

	// Parameter write; selects show it two cycles on
	task automatic prm(input logic [2:0] a, input logic [3:0] d, input logic [2:0] exp);
		u_bm.write(a, d);
		@(posedge mclk);
		#1 chk(16'({code_type_select, flag_mode_select, count_direction_select}), 16'(exp), "selects");
	endtask

	// One angle sample, held until taken, then time to drain
	task automatic push(input logic [12:0] v);
		@(posedge mclk);
		sens_valid <= 1'b1;
		sens_data <= v;
		do begin
			@(negedge mclk);
			rdy = sens_ready;
			@(posedge mclk);
		end while (!rdy);
		sens_valid <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		#1 chk(16'({code_type_select, flag_mode_select, count_direction_select, sens_ready}), 16'h1, "reset");
		pw(1'b0, 16'h0000);
		prm(3'h4, 4'b0111, 3'b111);
		prm(3'h5, 4'b0000, 3'b111);
		// Slave A writes every cycle stall the drain, so the buffer fills
		fork
			u_bm.write(3'h0, 4'h0, 40);
			begin
				@(posedge mclk);
				sens_valid <= 1'b1;
				sens_data <= 13'h1100;
				repeat (40) begin
					@(negedge mclk);
					rdy = sens_ready;
					full_seen = full_seen | !rdy;
					@(posedge mclk);
					if (rdy) begin
						taken++;
						sens_data <= sens_data + 13'h0001;
					end
				end
				sens_valid <= 1'b0;
			end
		join
		chk(16'(taken), 16'd32, "samples taken");
		chk(16'(full_seen), 16'h1, "buffer refused");
		repeat (40) @(posedge mclk);
		wl(3'h0, 4'b0100, 1'b0);
		u_bm.read(3'h1, w[3:0]);
		chk(16'(w[3:0]), 16'h0, "read before latch");
		wl(3'h0, 4'b1000, 1'b1);
		pw(1'b0, 16'h111f);
		wl(3'h1, 4'b0100, 1'b0);
		wl(3'h0, 4'b1010, 1'b0);
		repeat (2) @(posedge mclk);
		wl(3'h0, 4'b0100, 1'b1);
		pw(1'b0, 16'h0800);
		wl(3'h0, 4'b1100, 1'b0);
		wl(3'h0, 4'b0100, 1'b0);
		// Gray, flags, count up; zero preset then five steps
		prm(3'h4, 4'b0100, 3'b001);
		wl(3'h0, 4'b0101, 1'b0);
		push(13'h1124);
		wl(3'h0, 4'b1000, 1'b1);
		pw(1'b1, 16'h0007);
		wl(3'h0, 4'b0100, 1'b1);
		pw(1'b1, 16'h888f);
		// Binary, no flags, count down; three steps below zero
		prm(3'h4, 4'b0011, 3'b110);
		wl(3'h0, 4'b0101, 1'b0);
		push(13'h1127);
		wl(3'h0, 4'b1000, 1'b1);
		pw(1'b0, 16'h1ffd);
		// Frozen clock enable takes no command
		@(posedge mclk) ce <= 1'b0;
		wl(3'h0, 4'b0100, 1'b0);
		@(posedge mclk) ce <= 1'b1;
		pw(1'b0, 16'h1ffd);
		give_verdict();
	end
endmodule // test_absolute_encoder_four_slave_map

`default_nettype wire
